// *** rtl/cell_balance_sleep_control.sv ***
// balance switch, amplifier control, sleep gating and discharge gate logic
module cell_balance_sleep_control
    import cbsc_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_PULSE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       linkClk,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    input  wire logic       overheatRaw,
    input  wire logic       shortRaw,
    input  wire logic       wakeEventOne,
    input  wire logic       wakeEventTwo,
    input  wire logic       hvWakePinOne,
    input  wire logic       hvWakePinTwo,
    input  wire logic       dischargeGateIn0,
    input  wire logic       dischargeGateIn1,
    output logic      [7:0] balanceSwitchBits,
    output logic            currentAmpEnable,
    output logic            ampNull,
    output logic            ampGainSelect,
    output logic            shortDetectEnable,
    output logic            overheatDetectEnable,
    output logic            regulatorEnable,
    output logic            regulatorDischarge,
    output logic            dischargeGateOut0,
    output logic            dischargeGateOut1,
    output logic            interruptOut_n,
    output logic            sleepStatus
);
    typedef enum logic {AWAKE, ASLEEP} power_t;

    // three-stage synchroniser per pin, vector order below
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] asyncIn;
    logic [NSYNC-1:0] syncBits;
    assign asyncIn = {dischargeGateIn1, dischargeGateIn0, hvWakePinTwo, hvWakePinOne,
                      wakeEventTwo, wakeEventOne, shortRaw, overheatRaw};
    for (genvar g = 0; g < NSYNC; g++) begin : g_sync
        logic s1_r, s2_r, s3_r, hold_r, hold_nxt;
        // a change counts once stages two and three agree, so a lone glitch never passes
        always_comb begin
            hold_nxt = hold_r;
            if (s2_r == s3_r) begin
                hold_nxt = s3_r;
            end
        end
        // only stage two reads stage one
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                s1_r   <= 1'h0;
                s2_r   <= 1'h0;
                s3_r   <= 1'h0;
                hold_r <= 1'h0;
            end else begin
                s1_r   <= asyncIn[g];
                s2_r   <= s1_r;
                s3_r   <= s2_r;
                hold_r <= hold_nxt;
            end
        end
        assign syncBits[g] = hold_r;
    end

    // synchronised levels, same order as asyncIn
    logic overheatS, shortS, wake1S, wake2S, hv1S, hv2S, gate0S, gate1S;
    assign {gate1S, gate0S, hv2S, hv1S, wake2S, wake1S, shortS, overheatS} = syncBits;

    // register state
    logic [7:0] balance_r, balance_nxt;
    logic [7:0] ampCtrl_r, ampCtrl_nxt;
    logic [7:0] ohCtrl_r, ohCtrl_nxt;
    logic [7:0] flags_r, flags_nxt;
    logic       locked_r, locked_nxt;
    logic [7:0] prev_r, prev_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    power_t     power_r, power_nxt;
    logic [31:0] wakeCnt_r, wakeCnt_nxt;
    logic        ohActive, ohRise, wakeQualified, sleepCmd;
    logic        shortActive;

    // overheat is only watched with detect enabled and a switch on
    assign ohActive    = ohCtrl_r[OH_DETECT_POS] && (balance_r != 8'h00);
    assign ohRise      = ohActive && overheatS && !prev_r[FLAG_OVERHEAT_POS];
    assign shortActive = ampCtrl_r[SHORT_ENABLE_POS] && shortS;
    assign sleepCmd    = regWrite && (regAddr == CMD_SLEEP) &&
                         regWdata[SLEEP_BIT1_POS] && regWdata[SLEEP_BIT0_POS];
    assign wakeQualified = (wakeCnt_r >= 32'(WAKE_CYCLES - 1)) && (hv1S || hv2S);

    // register writes, lock, flags and power state
    always_comb begin
        balance_nxt = balance_r;
        ampCtrl_nxt = ampCtrl_r;
        ohCtrl_nxt  = ohCtrl_r;
        flags_nxt   = flags_r;
        locked_nxt  = locked_r;
        power_nxt   = power_r;
        wakeCnt_nxt = 32'h0000_0000;
        rdata_nxt   = rdata_r;
        prev_nxt    = {3'b000, ohActive && overheatS, wake2S, wake1S, 1'b0, shortActive};
        if (regWrite) begin
            unique case (regAddr)
                CMD_BALANCE: begin
                    if (regWdata == BALANCE_RELEASE) begin
                        locked_nxt = 1'b0;
                    end
                    if (!locked_r || regWdata == BALANCE_RELEASE) begin
                        balance_nxt = regWdata;
                    end
                end
                CMD_SLEEP: begin
                    // bit zero of a sleep command drops every switch, even when sleep is refused
                    if (regWdata[SLEEP_BIT0_POS]) begin
                        balance_nxt = 8'h00;
                    end
                end
                CMD_AMP_CTRL: ampCtrl_nxt = regWdata;
                CMD_OVERHEAT: ohCtrl_nxt  = regWdata;
                default: ;
            endcase
        end
        // reads return registered data; reading the flag register clears it
        if (regRead) begin
            unique case (regAddr)
                CMD_BALANCE:  rdata_nxt = balance_r;
                CMD_AMP_CTRL: rdata_nxt = ampCtrl_r;
                CMD_OVERHEAT: rdata_nxt = ohCtrl_r;
                CMD_INT_FLAG: rdata_nxt = flags_r;
                CMD_SLEEP:    rdata_nxt = {sleepStatus, sleepStatus, 6'h00};
                default:      rdata_nxt = 8'h00;
            endcase
            if (regAddr == CMD_INT_FLAG) begin
                flags_nxt = 8'h00;
            end
        end
        // new edges win over the read clear
        if (shortActive && !prev_r[FLAG_SHORT_POS]) begin
            flags_nxt[FLAG_SHORT_POS] = 1'b1;
        end
        if (wake1S && !prev_r[FLAG_WAKE1_POS]) begin
            flags_nxt[FLAG_WAKE1_POS] = 1'b1;
        end
        if (wake2S && !prev_r[FLAG_WAKE2_POS]) begin
            flags_nxt[FLAG_WAKE2_POS] = 1'b1;
        end
        if (ohRise) begin
            flags_nxt[FLAG_OVERHEAT_POS] = 1'b1;
        end
        // overheat auto-off; the lock outlives the heat so a stray
        // write cannot turn the switches back on before the host clears them
        if (ohRise && ohCtrl_r[OH_LOCK_POS]) begin
            balance_nxt = 8'h00;
            locked_nxt  = 1'b1;
        end
        // power state: sleep entry gated by both wake levels, exit by a long wake pulse
        unique case (power_r)
            AWAKE: begin
                if (sleepCmd && !wake1S && !wake2S) begin
                    power_nxt   = ASLEEP;
                    balance_nxt = 8'h00;
                end
            end
            ASLEEP: begin
                balance_nxt = 8'h00;
                if (hv1S || hv2S) begin
                    wakeCnt_nxt = wakeCnt_r + 32'h0000_0001;
                end
                if (wakeQualified) begin
                    power_nxt = AWAKE;
                end
            end
        endcase
    end

    // register state, power state and wake counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            balance_r <= BALANCE_RESET;
            ampCtrl_r <= AMP_CTRL_RESET;
            ohCtrl_r  <= OVERHEAT_RESET;
            flags_r   <= 8'h00;
            locked_r  <= 1'b0;
            prev_r    <= 8'h00;
            rdata_r   <= 8'h00;
            power_r   <= AWAKE;
            wakeCnt_r <= 32'h0000_0000;
        end else begin
            balance_r <= balance_nxt;
            ampCtrl_r <= ampCtrl_nxt;
            ohCtrl_r  <= ohCtrl_nxt;
            flags_r   <= flags_nxt;
            locked_r  <= locked_nxt;
            prev_r    <= prev_nxt;
            rdata_r   <= rdata_nxt;
            power_r   <= power_nxt;
            wakeCnt_r <= wakeCnt_nxt;
        end
    end

    // registered outputs, all shut down while asleep
    logic [7:0] outs_r, outs_nxt;
    always_comb begin
        outs_nxt = 8'h00;
        if (power_nxt == AWAKE) begin
            outs_nxt[0] = ampCtrl_nxt[AMP_ENABLE_POS];
            outs_nxt[1] = ampCtrl_nxt[AMP_NULL_POS];
            outs_nxt[2] = ampCtrl_nxt[AMP_GAIN_POS];
            outs_nxt[3] = ampCtrl_nxt[SHORT_ENABLE_POS];
            outs_nxt[4] = ohCtrl_nxt[OH_DETECT_POS] && (balance_nxt != 8'h00);
            outs_nxt[5] = gate0S;
            outs_nxt[6] = gate1S;
            outs_nxt[7] = 1'b1;
        end
    end
    // output register, updated in the same edge as the power state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outs_r <= 8'h00;
        end else begin
            outs_r <= outs_nxt;
        end
    end

    // regulator discharge switch, on for every cycle spent asleep
    logic regDischarge_r, regDischarge_nxt;
    always_comb begin
        regDischarge_nxt = (power_nxt == ASLEEP);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regDischarge_r <= 1'h0;
        end else begin
            regDischarge_r <= regDischarge_nxt;
        end
    end

    // pending flags, masked while asleep, registered so the crossing sees a clean level
    logic intReq_r, intReq_nxt;
    always_comb begin
        intReq_nxt = (flags_r != 8'h00) && (power_r == AWAKE);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intReq_r <= 1'h0;
        end else begin
            intReq_r <= intReq_nxt;
        end
    end

    // link-clock domain: two-flop synchroniser, then the registered pin
    logic intL1_r, intL2_r, intOut_n_r, intOut_n_nxt;
    always_comb begin
        intOut_n_nxt = !intL2_r; // pin is active low
    end
    always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
            intL1_r    <= 1'h0;
            intL2_r    <= 1'h0;
            intOut_n_r <= 1'h1;
        end else begin
            intL1_r    <= intReq_r;
            intL2_r    <= intL1_r;
            intOut_n_r <= intOut_n_nxt;
        end
    end

    // port assignments
    assign balanceSwitchBits    = balance_r;
    assign currentAmpEnable     = outs_r[0];
    assign ampNull              = outs_r[1];
    assign ampGainSelect        = outs_r[2];
    assign shortDetectEnable    = outs_r[3];
    assign overheatDetectEnable = outs_r[4];
    assign dischargeGateOut0    = outs_r[5];
    assign dischargeGateOut1    = outs_r[6];
    assign regulatorEnable      = outs_r[7];
    assign regulatorDischarge   = regDischarge_r;
    assign sleepStatus          = (power_r == ASLEEP);
    assign interruptOut_n       = intOut_n_r;
    assign regRdata             = rdata_r;
endmodule

// *** rtl/cbsc_pkg.sv ***
// constants shared by the balance, sleep and wake control logic
package cbsc_pkg;
    localparam logic [7:0] CMD_SLEEP       = 8'h00; // sleep command register
    localparam logic [7:0] CMD_BALANCE     = 8'h01; // balance switch register
    localparam logic [7:0] CMD_AMP_CTRL    = 8'h02; // amplifier / short detect control
    localparam logic [7:0] CMD_OVERHEAT    = 8'h06; // overheat control
    localparam logic [7:0] CMD_INT_FLAG    = 8'h09; // interrupt flag register
    localparam int SLEEP_BIT1_POS          = 7;
    localparam int SLEEP_BIT0_POS          = 6;
    localparam int AMP_ENABLE_POS          = 0;
    localparam int AMP_NULL_POS            = 1;
    localparam int AMP_GAIN_POS            = 2;
    localparam int SHORT_ENABLE_POS        = 3;
    localparam int OH_DETECT_POS           = 0;
    localparam int OH_LOCK_POS             = 1;
    localparam int FLAG_SHORT_POS          = 0;
    localparam int FLAG_WAKE1_POS          = 2;
    localparam int FLAG_WAKE2_POS          = 3;
    localparam int FLAG_OVERHEAT_POS       = 4;
    localparam logic [7:0] BALANCE_RESET   = 8'h00;
    localparam logic [7:0] BALANCE_RELEASE = 8'h00;
    localparam logic [7:0] AMP_CTRL_RESET  = 8'h00;
    localparam logic [7:0] OVERHEAT_RESET  = 8'h00;
    localparam int CLK_HZ                  = 20_000_000;
    localparam int WAKE_PULSE_US           = 1000; // minimum wake pulse width, 1 ms
    localparam int WAKE_PULSE_CYCLES       = (WAKE_PULSE_US * (CLK_HZ / 1_000_000));
endpackage

// *** verif/cell_balance_sleep_control_asserts.sv ***
// concurrent checks on the balance, amplifier, sleep and gate ports
module cell_balance_sleep_control_asserts
    import cbsc_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic       wakeEventOne,
    input wire logic       wakeEventTwo,
    input wire logic       dischargeGateIn0,
    input wire logic       dischargeGateIn1,
    input wire logic [7:0] balanceSwitchBits,
    input wire logic       currentAmpEnable,
    input wire logic       ampNull,
    input wire logic       ampGainSelect,
    input wire logic       shortDetectEnable,
    input wire logic       regulatorEnable,
    input wire logic       regulatorDischarge,
    input wire logic       dischargeGateOut0,
    input wire logic       dischargeGateOut1,
    input wire logic       sleepStatus
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // register writes and read-back
    AST_BAL_CLEAR: assert property (regWrite && regAddr == CMD_BALANCE && regWdata == BALANCE_RELEASE
        |=> balanceSwitchBits == 8'h00) else $error("balance not cleared by zero write");
    AST_BAL_READ: assert property (regRead && regAddr == CMD_BALANCE
        |=> regRdata == $past(balanceSwitchBits)) else $error("balance read-back wrong");
    AST_AMP_CTRL: assert property (regWrite && regAddr == CMD_AMP_CTRL && !sleepStatus
        |=> {shortDetectEnable, ampGainSelect, ampNull, currentAmpEnable} == $past(regWdata[3:0]))
        else $error("amplifier controls differ from write");
    // outputs held off while asleep, regulator discharge held on; no sleep entry with a wake input high
    AST_GATE_SLEEP: assert property (sleepStatus && $past(sleepStatus)
        |-> !dischargeGateOut0 && !dischargeGateOut1) else $error("gate driven in sleep");
    AST_REG_SLEEP: assert property (sleepStatus && $past(sleepStatus)
        |-> regulatorDischarge && !regulatorEnable && !currentAmpEnable && !shortDetectEnable)
        else $error("output active in sleep");
    AST_BAL_SLEEP: assert property (sleepStatus && $past(sleepStatus)
        |-> balanceSwitchBits == 8'h00) else $error("balance on in sleep");
    AST_WAKE_BLOCK: assert property ((wakeEventOne || wakeEventTwo) [*8]
        |-> !$rose(sleepStatus)) else $error("sleep entered with wake high");
    // gates follow their inputs when awake
    AST_GATE_FOLLOW0: assert property ((!sleepStatus && $stable(dischargeGateIn0)) [*6]
        |-> dischargeGateOut0 == dischargeGateIn0) else $error("gate 0 not following");
    AST_GATE_FOLLOW1: assert property ((!sleepStatus && $stable(dischargeGateIn1)) [*6]
        |-> dischargeGateOut1 == dischargeGateIn1) else $error("gate 1 not following");
endmodule

bind cell_balance_sleep_control cell_balance_sleep_control_asserts u_asserts (.clk(clk), .rst(rst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .wakeEventOne(wakeEventOne), .wakeEventTwo(wakeEventTwo), .dischargeGateIn0(dischargeGateIn0),
    .dischargeGateIn1(dischargeGateIn1), .balanceSwitchBits(balanceSwitchBits),
    .currentAmpEnable(currentAmpEnable), .ampNull(ampNull), .ampGainSelect(ampGainSelect),
    .shortDetectEnable(shortDetectEnable), .regulatorEnable(regulatorEnable),
    .regulatorDischarge(regulatorDischarge), .dischargeGateOut0(dischargeGateOut0),
    .dischargeGateOut1(dischargeGateOut1), .sleepStatus(sleepStatus));

// *** verif/host_model.sv ***
// host model issuing single-byte register writes and reads
module host_model (
    input  wire logic       clk,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWdata,
    input  wire logic [7:0] regRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus idle; no measurement path is modelled, so none runs while balancing
    initial begin
        {regWrite, regRead, regAddr, regWdata} = 18'h0ffff;
    end
    // strobe held one edge, then address and data scrambled
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        {regWrite, regAddr, regWdata} <= {1'b1, addr, data};
        @(posedge clk);
        {regWrite, regAddr, regWdata} <= {1'b0, ~addr, ~data};
    endtask
    // read strobe, data taken after the answering edge
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        {regRead, regAddr} <= {1'b1, addr};
        @(posedge clk);
        {regRead, regAddr} <= {1'b0, ~addr};
        @(negedge clk);
        data = regRdata;
    endtask
endmodule

// *** verif/cell_balance_sleep_control_tb.sv ***
// self-checking bench for the balance, sleep and gate control
`define CHK(what, exp, got) begin numChecks++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module cell_balance_sleep_control_tb
    import cbsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, linkClk = 1'b0, rst = 1'b1, regWrite, regRead;
    logic [7:0] regAddr, regWdata, regRdata, balanceSwitchBits, rdData;
    logic       overheatRaw, shortRaw, wakeEventOne, wakeEventTwo, hvWakePinOne, hvWakePinTwo;
    logic       dischargeGateIn0, dischargeGateIn1, currentAmpEnable, ampNull, ampGainSelect, shortDetectEnable;
    logic       overheatDetectEnable, regulatorEnable, regulatorDischarge, interruptOut_n, sleepStatus;
    logic       dischargeGateOut0, dischargeGateOut1;
    logic [3:0] ampOuts;
    assign ampOuts = {shortDetectEnable, ampGainSelect, ampNull, currentAmpEnable};
    logic [7:0] pats[4] = '{8'h01, 8'h80, 8'ha5, 8'h00};
    logic [7:0] ampPats[3] = '{8'h0f, 8'h05, 8'h0a};
    int         miscompares = 0, numChecks = 0;
    // system and link clocks
    always #25 clk = ~clk;
    always #32 linkClk = ~linkClk;
    cell_balance_sleep_control #(.WAKE_CYCLES(8)) u_dut (.clk(clk), .rst(rst), .linkClk(linkClk),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .overheatRaw(overheatRaw), .shortRaw(shortRaw), .wakeEventOne(wakeEventOne), .wakeEventTwo(wakeEventTwo),
        .hvWakePinOne(hvWakePinOne), .hvWakePinTwo(hvWakePinTwo), .dischargeGateIn0(dischargeGateIn0),
        .dischargeGateIn1(dischargeGateIn1), .balanceSwitchBits(balanceSwitchBits),
        .currentAmpEnable(currentAmpEnable), .ampNull(ampNull), .ampGainSelect(ampGainSelect),
        .shortDetectEnable(shortDetectEnable), .overheatDetectEnable(overheatDetectEnable),
        .regulatorEnable(regulatorEnable), .regulatorDischarge(regulatorDischarge),
        .dischargeGateOut0(dischargeGateOut0), .dischargeGateOut1(dischargeGateOut1),
        .interruptOut_n(interruptOut_n), .sleepStatus(sleepStatus));
    host_model u_host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata));
    // counts, verdict and end of run
    task automatic completeRun();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // bounded wait for a sleep state, looked at between clock edges
    task automatic waitSleep(input logic lvl);
        @(negedge clk);
        for (int n = 0; n < 200 && sleepStatus !== lvl; n++) @(negedge clk);
        `CHK("sleep state", lvl, sleepStatus)
        if (sleepStatus !== lvl) completeRun();
    endtask
    // let edges pass, then settle at the falling edge
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // main sequence
    initial begin
        {overheatRaw, shortRaw, wakeEventOne, wakeEventTwo} = 4'h0;
        {hvWakePinOne, hvWakePinTwo, dischargeGateIn0, dischargeGateIn1} = 4'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        idle(0);
        `CHK("reset balance", 8'h00, balanceSwitchBits)
        foreach (pats[i]) begin
            u_host.wr(CMD_BALANCE, pats[i]);
            idle(0);
            `CHK("balance bits", pats[i], balanceSwitchBits)
            u_host.rd(CMD_BALANCE, rdData);
            `CHK("balance read", pats[i], rdData)
        end
        foreach (ampPats[i]) begin
            u_host.wr(CMD_AMP_CTRL, ampPats[i]);
            idle(0);
            `CHK("amp ctrl", ampPats[i][3:0], ampOuts)
        end
        u_host.wr(CMD_OVERHEAT, 8'h03);
        u_host.wr(CMD_BALANCE, 8'h05);
        @(posedge clk) overheatRaw <= 1'b1;
        idle(10);
        `CHK("overheat off", 9'h000, {overheatDetectEnable, balanceSwitchBits})
        u_host.wr(CMD_BALANCE, 8'h05);
        idle(0);
        `CHK("locked write", 8'h00, balanceSwitchBits)
        @(posedge clk) overheatRaw <= 1'b0;
        idle(6);
        u_host.wr(CMD_BALANCE, 8'h00);
        u_host.wr(CMD_BALANCE, 8'h05);
        idle(0);
        `CHK("lock released", 8'h05, balanceSwitchBits)
        `CHK("detect active", 1'h1, overheatDetectEnable)
        @(posedge clk) {shortRaw, wakeEventOne, wakeEventTwo} <= 3'b111;
        idle(10);
        u_host.wr(CMD_SLEEP, 8'hc0);
        idle(20);
        `CHK("sleep refused", 1'b0, sleepStatus)
        `CHK("sleep cmd drops switches", 8'h00, balanceSwitchBits)
        `CHK("interrupt low", 1'h0, interruptOut_n)
        u_host.rd(CMD_INT_FLAG, rdData);
        `CHK("flags set", 8'h0d, rdData & 8'h0d)
        u_host.rd(CMD_INT_FLAG, rdData);
        `CHK("flags cleared", 8'h00, rdData & 8'h0d)
        idle(8);
        `CHK("interrupt high", 1'h1, interruptOut_n)
        @(posedge clk) {wakeEventOne, wakeEventTwo} <= 2'b00;
        idle(20);
        `CHK("sleep discarded", 1'b0, sleepStatus)
        @(posedge clk) {dischargeGateIn0, dischargeGateIn1} <= 2'b11;
        idle(6);
        `CHK("gates awake", 2'b11, {dischargeGateOut1, dischargeGateOut0})
        u_host.wr(CMD_SLEEP, 8'hc0);
        waitSleep(1'b1);
        idle(2);
        `CHK("sleep gates", 2'h0, {dischargeGateOut1, dischargeGateOut0})
        `CHK("sleep regulator", 2'h1, {regulatorEnable, regulatorDischarge})
        `CHK("sleep balance", 8'h00, balanceSwitchBits)
        @(posedge clk) hvWakePinOne <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        @(posedge clk) hvWakePinOne <= 1'b0;
        idle(20);
        `CHK("short pulse", 1'b1, sleepStatus)
        @(posedge clk) hvWakePinTwo <= 1'b1;
        waitSleep(1'b0);
        @(posedge clk) hvWakePinTwo <= 1'b0;
        idle(8);
        `CHK("awake outputs", 3'b111, {dischargeGateOut1, dischargeGateOut0, regulatorEnable})
        completeRun();
    end
endmodule
